/* File: rtl/dsk_drive_ctl.sv */
/*
  Diskette drive input control: decodes the controller's active-low
  strobes, positions the head, drives write, erase and load actuators,
  keeps the write fault latch, emits the revolution marker, and offers
  a small APB register file.
  Assumes all pins are synchronous to clk; one clock, synchronous reset.
*/
// Our own choices: the address map and register access over APB.
`timescale 1ns/100ps
module dsk_drive_ctl #(
  parameter int SETTLE_CYCLES = dsk_pkg::HOME_SETTLE_CYC,
  parameter int REV_CYCLES    = dsk_pkg::REV_PERIOD_CYC,
  parameter int INDEX_CYCLES  = dsk_pkg::INDEX_WIDTH_CYC
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        sys_rst,
  // Controller strobes, active low
  input  wire logic        step_n,
  input  wire logic        dir_in_n,
  input  wire logic        head_load_n,
  input  wire logic        fault_clr_n,
  input  wire logic        write_gate_n,
  input  wire logic        write_data_n,
  input  wire logic        erase_gate_n,
  input  wire logic        low_current_n,
  input  wire logic        unit_a_n,
  input  wire logic        unit_b_n,
  // Drive sensors
  input  wire logic        door_closed,
  // Status lines to the controller, active low
  output logic             home_n,
  output logic             fault_n,
  output logic             index_n,
  // Actuators
  output logic             head_solenoid,
  output logic             step_coil_pulse,
  output logic             step_coil_inward,
  output logic             write_current_on,
  output logic             write_coil_dir,
  output logic             write_reduced,
  output logic             erase_current_on,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic             pslverr,
  output logic [31:0]      prdata
);

  dsk_pos_if pos_if ();

  logic [1:0]  unit_reg;
  logic        wallow_reg;
  logic        step_prev_reg;
  logic        wdata_prev_reg;
  logic        fault_reg;
  logic [4:0]  fclr_cnt_reg;
  logic        pol_reg;
  logic        wcur_reg;
  logic        head_reg;
  logic        erase_reg;
  logic        lowcur_reg;
  logic        home_n_reg;
  logic        fault_n_reg;
  logic        index_n_reg;
  logic [24:0] rev_cnt_reg;
  logic [31:0] rev_total_reg;
  logic [31:0] prdata_reg;
  logic        selected;
  logic        gate_on;
  logic        fault_cond;
  logic        fclr_hit;
  logic        setup_ph;
  logic        access_ph;
  logic        mapped;
  logic        wr_ctrl;
  logic        wr_track;
  logic [31:0] status_word;
  logic [31:0] rd_word;

  // Drive address decode, active treated as one
  assign selected = ({~unit_b_n, ~unit_a_n} == unit_reg);

  assign gate_on = selected && !write_gate_n;

  // Head positioner
  dsk_head_pos #(
    .SETTLE_CYCLES (SETTLE_CYCLES)
  ) u_head_pos (
    .clk     (clk),
    .sys_rst (sys_rst),
    .p       (pos_if)
  );

  // Step edge, ignored while writing or not selected
  assign pos_if.step_go       = step_prev_reg && !step_n && selected && !gate_on;
  assign pos_if.toward_center = !dir_in_n;
  assign pos_if.track_load    = wr_track;
  assign pos_if.track_value   = pwdata[6:0];

  // Input edge history
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      step_prev_reg  <= 1'b1;
      wdata_prev_reg <= 1'b1;
    end
    else
    begin
      step_prev_reg  <= step_n;
      wdata_prev_reg <= write_data_n;
    end
  end

  // Fault conditions: writing with no head load or an open door
  assign fault_cond = gate_on && (head_load_n || !door_closed);

  // Clear needs the input low for the least pulse width
  assign fclr_hit = !fault_clr_n
                    && (fclr_cnt_reg == 5'(dsk_pkg::FCLR_MIN_CYCLES - 1));

  // Fault clear width counter
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      fclr_cnt_reg <= 5'h00;
    else if (fault_clr_n)
      fclr_cnt_reg <= 5'h00;
    else if (!fclr_hit)
      fclr_cnt_reg <= fclr_cnt_reg + 5'h01;
  end

  // Write fault latch; a new fault wins over a clear
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      fault_reg <= 1'b0;
    else if (fault_cond)
      fault_reg <= 1'b1;
    else if (fclr_hit)
      fault_reg <= 1'b0;
  end

  // Head load, erase and current level actuators
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      head_reg   <= 1'b0;
      erase_reg  <= 1'b0;
      lowcur_reg <= 1'b0;
    end
    else
    begin
      head_reg   <= selected && !head_load_n;
      erase_reg  <= selected && !erase_gate_n;
      lowcur_reg <= selected && !low_current_n;
    end
  end

  // Write current source, inhibited by a fault or software
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      wcur_reg <= 1'b0;
    else
      wcur_reg <= gate_on && !fault_reg && !fault_cond && wallow_reg;
  end

  // Coil current reverses on each falling write data edge while write current is on
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      pol_reg <= 1'b0;
    else if (wcur_reg && wdata_prev_reg && !write_data_n)
      pol_reg <= ~pol_reg;
  end

  // Revolution timer, free-running from reset
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      rev_cnt_reg   <= 25'h0000000;
      rev_total_reg <= 32'h00000000;
    end
    else if (rev_cnt_reg == 25'(REV_CYCLES - 1))
    begin
      rev_cnt_reg   <= 25'h0000000;
      rev_total_reg <= rev_total_reg + 32'h00000001;
    end
    else
      rev_cnt_reg <= rev_cnt_reg + 25'h0000001;
  end

  // Status outputs, inactive when not selected
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      home_n_reg  <= 1'b1;
      fault_n_reg <= 1'b1;
      index_n_reg <= 1'b1;
    end
    else
    begin
      home_n_reg  <= !(selected && pos_if.home);
      fault_n_reg <= !(selected && fault_reg);
      index_n_reg <= !(selected && rev_cnt_reg < 25'(INDEX_CYCLES));
    end
  end

  assign home_n           = home_n_reg;
  assign fault_n          = fault_n_reg;
  assign index_n          = index_n_reg;
  assign head_solenoid    = head_reg;
  assign step_coil_pulse  = pos_if.coil_step;
  assign step_coil_inward = pos_if.coil_inward;
  assign write_current_on = wcur_reg;
  assign write_coil_dir   = pol_reg;
  assign write_reduced    = lowcur_reg && wcur_reg;
  assign erase_current_on = erase_reg;

  // APB phase and address decode
  assign setup_ph  = psel && !penable;
  assign access_ph = psel && penable;
  assign mapped    = (paddr == dsk_pkg::OFS_CTRL) || (paddr == dsk_pkg::OFS_TRACK)
                     || (paddr == dsk_pkg::OFS_STATUS) || (paddr == dsk_pkg::OFS_REVCNT);
  assign wr_ctrl   = access_ph && pwrite && (paddr == dsk_pkg::OFS_CTRL);
  assign wr_track  = access_ph && pwrite && (paddr == dsk_pkg::OFS_TRACK);
  assign pready    = 1'b1;
  assign pslverr   = access_ph && !mapped;

  // Control register
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      unit_reg   <= dsk_pkg::UNIT_RESET;
      wallow_reg <= dsk_pkg::WALLOW_RESET;
    end
    else if (wr_ctrl)
    begin
      unit_reg   <= pwdata[dsk_pkg::CTRL_UNIT_LSB +: 2];
      wallow_reg <= pwdata[dsk_pkg::CTRL_WALLOW_BIT];
    end
  end

  // Status word assembly
  always_comb
  begin
    status_word                        = 32'h00000000;
    status_word[6:0]                   = pos_if.track;
    status_word[dsk_pkg::ST_HOME_BIT]   = pos_if.home;
    status_word[dsk_pkg::ST_FAULT_BIT]  = fault_reg;
    status_word[dsk_pkg::ST_HEAD_BIT]   = head_reg;
    status_word[dsk_pkg::ST_WCUR_BIT]   = wcur_reg;
    status_word[dsk_pkg::ST_POL_BIT]    = pol_reg;
    status_word[dsk_pkg::ST_ERASE_BIT]  = erase_reg;
    status_word[dsk_pkg::ST_LOWCUR_BIT] = lowcur_reg;
    status_word[dsk_pkg::ST_SEL_BIT]    = selected;
    status_word[dsk_pkg::ST_BUSY_BIT]   = pos_if.busy;
  end

  // Read mux
  always_comb
  begin
    rd_word = 32'h00000000;
    unique case (paddr)
      dsk_pkg::OFS_CTRL:
        rd_word = {29'h00000000, wallow_reg, unit_reg};
      dsk_pkg::OFS_TRACK:
        rd_word = {25'h0000000, pos_if.track};
      dsk_pkg::OFS_STATUS:
        rd_word = status_word;
      dsk_pkg::OFS_REVCNT:
        rd_word = rev_total_reg;
      default:
        rd_word = 32'h00000000;
    endcase
  end

  // Read data captured in the setup cycle
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      prdata_reg <= 32'h00000000;
    else if (setup_ph)
      prdata_reg <= pwrite ? 32'h00000000 : rd_word;
  end

  assign prdata = prdata_reg;

endmodule

/* File: rtl/dsk_pkg.sv */
/*
  Constants shared by the diskette drive input control block: register
  offsets, field positions, reset values and timing figures.
  Assumes a 100 MHz clock; all counts are derived from that period.
*/
package dsk_pkg;

  // Clock period
  localparam int CLK_NS = 10;

  // Register byte offsets
  localparam logic [11:0] OFS_CTRL   = 12'h000;
  localparam logic [11:0] OFS_TRACK  = 12'h004;
  localparam logic [11:0] OFS_STATUS = 12'h008;
  localparam logic [11:0] OFS_REVCNT = 12'h00c;

  // Control register fields and reset values
  localparam int          CTRL_UNIT_LSB   = 0;
  localparam int          CTRL_WALLOW_BIT = 2;
  localparam logic [1:0]  UNIT_RESET      = 2'h0;
  localparam logic        WALLOW_RESET    = 1'b1;

  // Status register fields
  localparam int ST_HOME_BIT   = 7;
  localparam int ST_FAULT_BIT  = 8;
  localparam int ST_HEAD_BIT   = 9;
  localparam int ST_WCUR_BIT   = 10;
  localparam int ST_POL_BIT    = 11;
  localparam int ST_ERASE_BIT  = 12;
  localparam int ST_LOWCUR_BIT = 13;
  localparam int ST_SEL_BIT    = 14;
  localparam int ST_BUSY_BIT   = 15;

  // Track range
  localparam logic [6:0] TRACK_HOME = 7'h00;
  localparam logic [6:0] TRACK_LAST = 7'h4c;

  // Direction sample delay after the step falling edge
  localparam int DIR_SAMPLE_NS     = 100;
  localparam int DIR_SAMPLE_CYCLES = DIR_SAMPLE_NS / CLK_NS;

  // Least low time on the fault clear input
  localparam int FCLR_MIN_NS     = 200;
  localparam int FCLR_MIN_CYCLES = (FCLR_MIN_NS + CLK_NS - 1) / CLK_NS;

  // Home indication settle, revolution period, marker width
  localparam int HOME_SETTLE_MS  = 10;
  localparam int REV_PERIOD_US   = 166700;
  localparam int INDEX_WIDTH_US  = 450;
  localparam int HOME_SETTLE_CYC = HOME_SETTLE_MS * 1000000 / CLK_NS;
  localparam int REV_PERIOD_CYC  = REV_PERIOD_US * 1000 / CLK_NS;
  localparam int INDEX_WIDTH_CYC = INDEX_WIDTH_US * 1000 / CLK_NS;

endpackage

/* File: rtl/dsk_pos_if.sv */
/*
  Interface between the drive control logic and the head positioner.
  Assumes both ends run on the same clock.
*/
`timescale 1ns/100ps
interface dsk_pos_if;
  logic       step_go;
  logic       toward_center;
  logic       track_load;
  logic [6:0] track_value;
  logic [6:0] track;
  logic       home;
  logic       busy;
  logic       coil_step;
  logic       coil_inward;

  modport ctl (output step_go, toward_center, track_load, track_value,
               input  track, home, busy, coil_step, coil_inward);
  modport pos (input  step_go, toward_center, track_load, track_value,
               output track, home, busy, coil_step, coil_inward);
endinterface

/* File: rtl/dsk_head_pos.sv */
/*
  Head positioner: samples direction after each accepted step, moves the
  track position one place, and times the settle of the home indication.
  Assumes step_go is a one-cycle pulse already gated by select and lockout.
*/
`timescale 1ns/100ps
module dsk_head_pos #(
  parameter int SETTLE_CYCLES = dsk_pkg::HOME_SETTLE_CYC
) (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Positioner side
  dsk_pos_if.pos   p
);

  logic       pend_reg;
  logic [3:0] samp_cnt_reg;
  logic       sample_now;
  logic [6:0] track_reg;
  logic       coil_step_reg;
  logic       coil_in_reg;
  logic [19:0] settle_cnt_reg;
  logic       busy_reg;
  logic       home_reg;

  assign sample_now = pend_reg && (samp_cnt_reg == 4'(dsk_pkg::DIR_SAMPLE_CYCLES - 1));

  // Delay from step edge to direction sample
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      pend_reg     <= 1'b0;
      samp_cnt_reg <= 4'h0;
    end
    else if (p.step_go && !pend_reg)
    begin
      pend_reg     <= 1'b1;
      samp_cnt_reg <= 4'h0;
    end
    else if (sample_now)
      pend_reg <= 1'b0;
    else if (pend_reg)
      samp_cnt_reg <= samp_cnt_reg + 4'h1;
  end

  // One track per step, direction from the sampled line
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      track_reg <= dsk_pkg::TRACK_HOME;
    else if (p.track_load)
      track_reg <= p.track_value;
    else if (sample_now && p.toward_center && track_reg != dsk_pkg::TRACK_LAST)
      track_reg <= track_reg + 7'h01;
    else if (sample_now && !p.toward_center && track_reg != dsk_pkg::TRACK_HOME)
      track_reg <= track_reg - 7'h01;
  end

  // Stepper coil drive pulse
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      coil_step_reg <= 1'b0;
      coil_in_reg   <= 1'b0;
    end
    else
    begin
      coil_step_reg <= sample_now;
      if (sample_now)
        coil_in_reg <= p.toward_center;
    end
  end

  // Home indication valid only once the head has settled
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      settle_cnt_reg <= 20'h00000;
      busy_reg       <= 1'b1;
      home_reg       <= 1'b0;
    end
    else if (sample_now || p.track_load)
    begin
      settle_cnt_reg <= 20'h00000;
      busy_reg       <= 1'b1;
    end
    else if (busy_reg)
    begin
      if (settle_cnt_reg == 20'(SETTLE_CYCLES - 1))
      begin
        busy_reg <= 1'b0;
        home_reg <= (track_reg == dsk_pkg::TRACK_HOME);
      end
      else
        settle_cnt_reg <= settle_cnt_reg + 20'h00001;
    end
  end

  assign p.track       = track_reg;
  assign p.home        = home_reg;
  assign p.busy        = busy_reg;
  assign p.coil_step   = coil_step_reg;
  assign p.coil_inward = coil_in_reg;

endmodule

/* File: dv/dsk_host_model.sv */
/*
  Host controller model: drives step, direction and flux strobes.
  Assumes one-cycle requests from the bench on clk.
*/
`timescale 1ns/100ps
module dsk_host_model #(
  parameter int STEP_LOW = 1000,
  parameter int STEP_GAP = 100
) (
  // Clock
  input  wire logic clk,
  // Requests from the bench
  input  wire logic step_req,
  input  wire logic step_inward,
  input  wire logic flux_req,
  // Strobes to the drive
  output logic      step_n,
  output logic      dir_in_n,
  output logic      write_data_n,
  output logic      busy
);
  int scnt = 0;
  int fcnt = 0;

  initial dir_in_n = 1'b1;

  // Direction set first and held past the step edge
  always @(posedge clk)
    if (step_req && scnt == 0)
    begin
      dir_in_n <= !step_inward;
      scnt     <= STEP_LOW + STEP_GAP + 4;
    end
    else if (scnt != 0)
      scnt <= scnt - 1;

  // One low step pulse, then a short spacing gap
  assign step_n = !(scnt > STEP_GAP + 2 && scnt <= STEP_LOW + STEP_GAP + 2);

  // Flux pulse 200 ns low, then as long high
  always @(posedge clk)
    if (flux_req && fcnt == 0)
      fcnt <= 40;
    else if (fcnt != 0)
      fcnt <= fcnt - 1;

  assign write_data_n = !(fcnt > 20);
  assign busy         = scnt != 0 || fcnt != 0;
endmodule

/* File: dv/dsk_drive_ctl_props.sv */
/*
  Port checker for the drive control block.
  Assumes the unit number changes only by APB writes to offset 0.
*/
`timescale 1ns/100ps
module dsk_drive_ctl_props #(
  parameter int INDEX_CYCLES = 10
) (
  // Clock and reset
  input wire logic        clk,
  input wire logic        sys_rst,
  // Strobes
  input wire logic        step_n,
  input wire logic        dir_in_n,
  input wire logic        head_load_n,
  input wire logic        write_gate_n,
  input wire logic        write_data_n,
  input wire logic        unit_a_n,
  input wire logic        unit_b_n,
  // Outputs
  input wire logic        home_n,
  input wire logic        fault_n,
  input wire logic        index_n,
  input wire logic        head_solenoid,
  input wire logic        step_coil_pulse,
  input wire logic        step_coil_inward,
  input wire logic        write_current_on,
  input wire logic        write_coil_dir,
  // APB
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata
);
  logic [1:0] unit_q;
  logic       sel;
  logic       ok;
  int         cnt;

  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);

  // Selection as the drive sees it
  assign sel = ({~unit_b_n, ~unit_a_n} == unit_q);

  // Own unit number mirrored from APB writes
  always_ff @(posedge clk)
    if (sys_rst)
      unit_q <= 2'h0;
    else if (psel && penable && pwrite && paddr == 12'h000)
      unit_q <= pwdata[1:0];

  // Marker low time, valid only while selected throughout
  always_ff @(posedge clk)
  begin
    cnt <= $fell(index_n) ? 0 : cnt + 1;
    ok  <= (sys_rst || !sel) ? 1'b0 : ($fell(index_n) ? 1'b1 : ok);
  end

  a_step_move: assert property (
    $fell(step_n) && sel && write_gate_n && !dir_in_n
    |-> ##[10:12] step_coil_pulse && step_coil_inward) else $error("step not moved in");
  a_step_lock: assert property (
    $fell(step_n) && (!write_gate_n || !sel)
    |-> ##5 !step_coil_pulse [*8]) else $error("locked step moved");
  a_flux_rev: assert property (
    $fell(write_data_n) && write_current_on
    |=> ##[0:1] $changed(write_coil_dir)) else $error("coil not reversed");
  a_wcur_cause: assert property (
    write_current_on |-> $past(!write_gate_n) && $past(!head_load_n))
    else $error("write current without gate");
  a_fault_inh: assert property (
    !fault_n && $past(!fault_n) |-> !write_current_on) else $error("current during fault");
  a_head_eng: assert property (
    $past(sel) |-> head_solenoid == $past(!head_load_n)) else $error("head load wrong");
  a_unsel_quiet: assert property (
    !sel && $past(!sel) && $past(!sel, 2)
    |-> home_n && fault_n && index_n && !head_solenoid) else $error("unselected active");
  a_idx_width: assert property (
    $rose(index_n) && ok |-> cnt == INDEX_CYCLES - 1) else $error("marker width wrong");
endmodule

bind dsk_drive_ctl dsk_drive_ctl_props #(.INDEX_CYCLES(INDEX_CYCLES)) props_inst (.*);

/* File: dv/tb.sv */
/*
  Self-checking bench for the drive control block.
  Assumes short settle and revolution counts and the host model.
*/
`timescale 1ns/100ps
module tb;
  // Design inputs
  logic        clk = 0, sys_rst = 1, head_load_n = 1, fault_clr_n = 1;
  logic        write_gate_n = 1, erase_gate_n = 1, low_current_n = 1;
  logic        unit_a_n = 1, unit_b_n = 1, door_closed = 1;
  logic        psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  // Design outputs and host strobes
  logic        step_n, dir_in_n, write_data_n, home_n, fault_n, index_n;
  logic        head_solenoid, step_coil_pulse, step_coil_inward, write_current_on;
  logic        write_coil_dir, write_reduced, erase_current_on, pready, pslverr;
  logic        step_req = 0, step_inward = 0, flux_req = 0, busy, err, cdir = 0;
  int          miscompares = 0, checks = 0, cycles = 0;

  always #5 clk = ~clk;

  dsk_drive_ctl #(.SETTLE_CYCLES(50), .REV_CYCLES(200), .INDEX_CYCLES(10))
    dsk_drive_ctl_inst (.*);
  dsk_host_model #(.STEP_LOW(1000), .STEP_GAP(100)) dsk_host_model_inst (.*);

  task automatic summarize();
    if (miscompares == 0 && checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask

  // One APB transfer, waiting on pready
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1)
      @(posedge clk);
    rd      = prdata;
    err     = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  // Step or flux request to the host model, then wait idle
  task automatic host(input logic st, input logic inward);
    step_req    <= st;
    flux_req    <= !st;
    step_inward <= inward;
    @(posedge clk);
    step_req    <= 1'b0;
    flux_req    <= 1'b0;
    @(posedge clk);
    while (busy === 1'b1)
      @(posedge clk);
  endtask

  // Main sequence
  initial
  begin
    cyc(12);
    sys_rst <= 1'b0;
    cyc(60);
    chk(home_n, 0);
    apb(0, 12'h000, 0);
    chk(rd, 32'h4);
    apb(0, 12'h010, 0);
    chk(err, 1);
    chk(rd, 0);
    for (int i = 0; i < 4; i++)
      host(1, i < 3);
    apb(0, 12'h008, 0);
    chk(rd[6:0], 2);
    chk(home_n, 1);
    // Locked out while writing, ignored while unselected
    head_load_n  <= 1'b0;
    write_gate_n <= 1'b0;
    host(1, 1);
    write_gate_n <= 1'b1;
    unit_a_n     <= 1'b0;
    host(1, 1);
    unit_a_n     <= 1'b1;
    apb(0, 12'h008, 0);
    chk(rd[6:0], 2);
    host(1, 0);
    host(1, 0);
    chk(home_n, 0);
    // Write path levels and flux reversals
    erase_gate_n  <= 1'b0;
    low_current_n <= 1'b0;
    write_gate_n  <= 1'b0;
    cyc(3);
    chk(write_current_on, 1);
    chk(erase_current_on, 1);
    chk(write_reduced, 1);
    chk(head_solenoid, 1);
    for (int i = 0; i < 3; i++)
    begin
      host(0, 0);
      cdir = ~cdir;
      chk(write_coil_dir, cdir);
    end
    // Head released mid-write trips the fault latch
    head_load_n <= 1'b1;
    cyc(3);
    chk(fault_n, 0);
    chk(write_current_on, 0);
    write_gate_n  <= 1'b1;
    erase_gate_n  <= 1'b1;
    low_current_n <= 1'b1;
    fault_clr_n   <= 1'b0;
    cyc(10);
    fault_clr_n   <= 1'b1;
    cyc(3);
    chk(fault_n, 0);
    fault_clr_n   <= 1'b0;
    cyc(22);
    fault_clr_n   <= 1'b1;
    cyc(3);
    chk(fault_n, 1);
    // Write allow off keeps current off
    apb(1, 12'h000, 0);
    head_load_n  <= 1'b0;
    write_gate_n <= 1'b0;
    cyc(3);
    chk(write_current_on, 0);
    write_gate_n <= 1'b1;
    head_load_n  <= 1'b1;
    // Each unit code selects its own number, not the code differing in bit 0
    for (int u = 0; u < 4; u++)
    begin
      apb(1, 12'h000, 32'h4 | u);
      {unit_b_n, unit_a_n} <= ~u[1:0];
      cyc(3);
      apb(0, 12'h008, 0);
      chk(rd[14], 1);
      {unit_b_n, unit_a_n} <= ~(u[1:0] ^ 2'h1);
      cyc(3);
      apb(0, 12'h008, 0);
      chk(rd[14], 0);
      chk(home_n, 1);
    end
    {unit_b_n, unit_a_n} <= 2'h3;
    apb(1, 12'h000, 32'h4);
    // Track preset restarts the settle timer
    apb(1, 12'h004, 32'h2c);
    apb(0, 12'h008, 0);
    chk(rd[15], 1);
    apb(0, 12'h004, 0);
    chk(rd, 32'h2c);
    chk(pready, 1);
    // Door opened while writing
    door_closed  <= 1'b0;
    write_gate_n <= 1'b0;
    cyc(3);
    chk(fault_n, 0);
    cyc(400);
    summarize();
  end

  // Hang guard
  always @(posedge clk)
  begin
    cycles++;
    if (cycles > 30000)
    begin
      miscompares++;
      summarize();
    end
  end
endmodule
